// File: rtl/flash_front_map.vh
// Purpose: named constants of the serial flash command front end
// Assumes: included by the front end and nothing else needs processes here
// Notes: clock counts are in serial clock periods, times in nanoseconds
`ifndef FLASH_FRONT_MAP_VH
`define FLASH_FRONT_MAP_VH

// opcodes
`define OP_RESET_ARM 8'h66
`define OP_RESET_GO 8'h99
`define OP_NO_OPERATION 8'h00
`define OP_QUAD_ENTER 8'h38
`define OP_QUAD_EXIT 8'hFF
`define OP_READ 8'h03
`define OP_QUAD_OUT_READ 8'h6B
`define OP_QUAD_IO_READ 8'hEB
`define OP_DUAL_OUT_READ 8'h3B
`define OP_DUAL_IO_READ 8'hBB
`define OP_SECTOR_ERASE 8'h20
`define OP_BLOCK_ERASE 8'hD8

// lane widths
`define LANE_X1 3'h1
`define LANE_X2 3'h2
`define LANE_X4 3'h4

// serial clock periods per phase
`define OPC_CLK_SER 5'h08
`define OPC_CLK_QUAD 5'h02
`define ADDR_CLK_X1 5'h18
`define ADDR_CLK_X2 5'h0C
`define ADDR_CLK_X4 5'h06
`define DUMMY_CLK_NONE 5'h00
`define DUMMY_CLK_X1 5'h08
`define DUMMY_CLK_DIO 5'h04
`define DUMMY_CLK_QIO 5'h06
`define BYTE_BITS 4'h8

// erase address granularity (lowest decoded bit)
`define SECT_LSB 12
`define BLK8_LSB 13
`define BLK32_LSB 15
`define BLK64_LSB 16

// reset values and kept status bits
`define STATUS_RST 8'h00
`define STATUS_KEEP 8'h30
`define BURST_RST 2'h0
`define IO_CFG_RST 1'b0
`define OE_N_ALL_OFF 4'hF
`define OE_N_X4 4'h0
`define OE_N_X2 4'hC
`define OE_N_X1 4'hD

// timing
`define MCLK_PERIOD_NS 4
`define RCV_WRITE_NS 40000
`define RCV_OTHER_NS 1000

`endif

// File: rtl/pin_sync.v
// Purpose: two-flop synchroniser for a group of pin levels
// Assumes: each bit is an independent level
// Notes: first stage feeds only the second stage
`timescale 1ns/1ns
module pin_sync #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
   // clock and reset
   input wire mclk,
   input wire srst,
   // levels
   input wire [WIDTH-1:0] din,
   output reg [WIDTH-1:0] dout
);
   reg [WIDTH-1:0] meta_q;

   always @(posedge mclk) begin
      if (srst) begin
         meta_q <= RST_VAL;
         dout <= RST_VAL;
      end else begin
         meta_q <= din;
         dout <= meta_q;
      end
   end
endmodule // pin_sync

// File: rtl/byte_fifo.v
// Purpose: synchronous FIFO with valid/ready on both sides and flush
// Assumes: one clock
// Notes: flush empties the queue in one cycle
`timescale 1ns/1ns
module byte_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16
) (
   // clock and reset
   input wire mclk,
   input wire srst,
   input wire flush,
   // fill side
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   // drain side
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   localparam AW = $clog2(DEPTH);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0] wr_q;
   reg [AW:0] rd_q;
   wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   wire empty = (wr_q == rd_q);

   assign in_ready = ~full;
   assign out_valid = ~empty;
   assign out_data = mem[rd_q[AW-1:0]];

   always @(posedge mclk) begin
      if (in_valid && !full) begin
         mem[wr_q[AW-1:0]] <= in_data;
      end
   end

   always @(posedge mclk) begin
      if (srst || flush) begin
         wr_q <= {(AW+1){1'b0}};
         rd_q <= {(AW+1){1'b0}};
      end else begin
         if (in_valid && !full) begin
            wr_q <= wr_q + 1'b1;
         end
         if (out_ready && !empty) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end
endmodule // byte_fifo

// File: rtl/flash_front_end.v
// Purpose: command front end of a quad serial flash, sampled on mclk
// Assumes: serial clock far slower than mclk; array answers within a few
//    mclk cycles of a request
// Notes: serial clock, chip select and data pins are all synchronised
// How it works
// - opcode takes 2 serial clocks in quad, 8 in one-bit protocol.
// - address, dummy and data bytes take 2 clocks on four lines, 4 on two lines, 8 on one line.
// - address bits above the array size are dropped.
// - reset executes only right after reset arm; any other completed opcode disarms.
// - no-operation only cancels a pending reset arm.
// - reset restores serial protocol, burst 8, clears io config and all status bits except 5:4.
// - reset during program or erase aborts it.
// - recovery after aborting a write lasts longer than otherwise.
// - basic read decodes only in one-bit protocol.
// - basic read is opcode then 24 address bits, no dummy.
// - read streams bytes with incrementing address until select rises.
// - read pointer wraps from top address to zero.
// - quad entry holds quad protocol until exit, software reset or power cycle.
// - quad exit accepted as 8-clock serial or 2-clock quad opcode.
// - quad output read sends data at two clocks a byte, needs io config.
// - quad io read moves address, dummy, data on four lines, io config.
// - dual reads take four clocks per byte on two lines.
// - sector erase decodes address down to bit 12.
// - block erase decodes to bit 16, 15 or 13 by location.
// - quad exit returns to one-bit protocol in either protocol.
// - one-bit serial protocol after power-up.
`timescale 1ns/1ns
`include "flash_front_map.vh"
module flash_front_end #(
   parameter ADDR_BITS = 21,
   parameter FIFO_DEPTH = 16,
   parameter RCV_WRITE_CYC =
      (`RCV_WRITE_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS,
   parameter RCV_OTHER_CYC =
      (`RCV_OTHER_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS
) (
   // clock and reset
   input wire mclk,
   input wire srst,
   // flash pins
   input wire cs_n,
   input wire sck,
   input wire [3:0] sio_in,
   output reg [3:0] sio_out,
   output reg [3:0] sio_oe_n,
   // array read port
   output wire arr_req_valid,
   input wire arr_req_ready,
   output wire [ADDR_BITS-1:0] arr_req_addr,
   input wire arr_rd_valid,
   output wire arr_rd_ready,
   input wire [7:0] arr_rd_data,
   // erase and abort
   output reg erase_valid,
   output reg erase_block,
   output reg [ADDR_BITS-1:0] erase_addr,
   input wire array_busy,
   output reg write_abort,
   // status and configuration
   input wire status_wr,
   input wire [7:0] status_wdata,
   output reg [7:0] status_q,
   input wire io_cfg_wr,
   input wire io_cfg_wdata,
   output reg io_configuration_bit,
   input wire burst_wr,
   input wire [1:0] burst_wdata,
   output reg [1:0] burst_len_q,
   output reg quad_mode_q,
   output reg reset_armed_q,
   output reg sw_reset_pulse,
   output wire dev_ready
);
   localparam [5:0] S_IDLE = 6'h01;
   localparam [5:0] S_OPC = 6'h02;
   localparam [5:0] S_ADDR = 6'h04;
   localparam [5:0] S_DUMMY = 6'h08;
   localparam [5:0] S_DATA = 6'h10;
   localparam [5:0] S_SKIP = 6'h20;
   localparam CW = $clog2(FIFO_DEPTH) + 1;

   // decoded command: {read, erase, block, addr lanes, addr clk,
   // dummy clk, data lanes}
   function [18:0] decode(input [7:0] op, input quad, input cfg);
      begin
         decode = 19'h00000;
         case (op)
            `OP_READ: if (!quad) decode = {3'b100, `LANE_X1,
               `ADDR_CLK_X1, `DUMMY_CLK_NONE, `LANE_X1};
            `OP_QUAD_OUT_READ: if (!quad && cfg) decode = {3'b100,
               `LANE_X1, `ADDR_CLK_X1, `DUMMY_CLK_X1, `LANE_X4};
            `OP_QUAD_IO_READ: if (!quad && cfg) decode = {3'b100,
               `LANE_X4, `ADDR_CLK_X4, `DUMMY_CLK_QIO, `LANE_X4};
            `OP_DUAL_OUT_READ: if (!quad) decode = {3'b100, `LANE_X1,
               `ADDR_CLK_X1, `DUMMY_CLK_X1, `LANE_X2};
            `OP_DUAL_IO_READ: if (!quad) decode = {3'b100, `LANE_X2,
               `ADDR_CLK_X2, `DUMMY_CLK_DIO, `LANE_X2};
            `OP_SECTOR_ERASE, `OP_BLOCK_ERASE: begin
               decode[17] = 1'b1;
               decode[16] = (op == `OP_BLOCK_ERASE);
               decode[15:13] = quad ? `LANE_X4 : `LANE_X1;
               decode[12:8] = quad ? `ADDR_CLK_X4 : `ADDR_CLK_X1;
            end
            default: decode = 19'h00000;
         endcase
      end
   endfunction

   // lowest address of the sector or block holding a
   function [ADDR_BITS-1:0] erase_base(input [ADDR_BITS-1:0] a,
         input blk);
      reg [ADDR_BITS-1:0] m;
      reg bot;
      reg top;
      begin
         m = {ADDR_BITS{1'b1}};
         bot = ~|a[ADDR_BITS-1:`BLK64_LSB];
         top = &a[ADDR_BITS-1:`BLK64_LSB];
         if (!blk) begin
            m = m << `SECT_LSB;
         end else if (bot || top) begin
            if (bot ^ a[`BLK32_LSB]) begin
               m = m << `BLK8_LSB;
            end else begin
               m = m << `BLK32_LSB;
            end
         end else begin
            m = m << `BLK64_LSB;
         end
         erase_base = a & m;
      end
   endfunction

   function [3:0] lane_bits(input [7:0] b, input [2:0] l);
      begin
         case (l)
            `LANE_X4: lane_bits = b[7:4];
            `LANE_X2: lane_bits = {2'b00, b[7:6]};
            default: lane_bits = {2'b00, b[7], 1'b0};
         endcase
      end
   endfunction

   function [3:0] lane_oe_n(input [2:0] l);
      begin
         case (l)
            `LANE_X4: lane_oe_n = `OE_N_X4;
            `LANE_X2: lane_oe_n = `OE_N_X2;
            default: lane_oe_n = `OE_N_X1;
         endcase
      end
   endfunction

   wire [5:0] pins_s;
   reg sck_d_q;
   reg cs_d_q;
   reg [5:0] state_q;
   reg [4:0] cnt_q;
   reg [31:0] in_sr_q;
   reg [31:0] in_sr_d;
   reg [7:0] opc_q;
   reg op_done_q;
   reg [18:0] dec_q;
   reg [7:0] out_sr_q;
   reg [3:0] out_cnt_q;
   reg rd_active_q;
   reg [ADDR_BITS-1:0] rd_ptr_q;
   reg [CW-1:0] credit_q;
   reg [31:0] rcv_cnt_q;
   reg [18:0] dec_now;

   wire cs_s = pins_s[5];
   wire sck_s = pins_s[4];
   wire [3:0] sio_s = pins_s[3:0];
   wire sck_rise = sck_s & ~sck_d_q;
   wire sck_fall = ~sck_s & sck_d_q;
   wire cs_rise = cs_s & ~cs_d_q;
   wire cs_fall = ~cs_s & cs_d_q;
   wire [2:0] a_lanes = dec_q[15:13];
   wire [4:0] dummy_clk = dec_q[7:3];
   wire [2:0] d_lanes = dec_q[2:0];
   wire fifo_valid;
   wire [7:0] fifo_data;
   wire pop = (state_q == S_DATA) && sck_fall && (out_cnt_q == 4'h0);
   wire popped = pop && fifo_valid;
   wire req_take = arr_req_valid && arr_req_ready;
   wire [ADDR_BITS-1:0] addr_in = in_sr_d[ADDR_BITS-1:0];

   assign arr_req_valid = rd_active_q &&
      (credit_q < FIFO_DEPTH[CW-1:0]); // sized to never overrun the fifo
   assign arr_req_addr = rd_ptr_q;
   assign dev_ready = (rcv_cnt_q == 32'h0);

   pin_sync #(.WIDTH(6), .RST_VAL(6'h20)) u_sync (
      .mclk(mclk),
      .srst(srst),
      .din({cs_n, sck, sio_in}),
      .dout(pins_s)
   );

   byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .mclk(mclk),
      .srst(srst),
      .flush(~rd_active_q),
      .in_valid(arr_rd_valid & rd_active_q),
      .in_ready(arr_rd_ready),
      .in_data(arr_rd_data),
      .out_valid(fifo_valid),
      .out_ready(pop),
      .out_data(fifo_data)
   );

   // shift in by the lane count of the current phase
   always @* begin
      case ((state_q == S_OPC) ? (quad_mode_q ? `LANE_X4 : `LANE_X1)
            : a_lanes)
         `LANE_X4: in_sr_d = {in_sr_q[27:0], sio_s};
         `LANE_X2: in_sr_d = {in_sr_q[29:0], sio_s[1:0]};
         default: in_sr_d = {in_sr_q[30:0], sio_s[0]};
      endcase
      dec_now = decode(in_sr_d[7:0], quad_mode_q, io_configuration_bit);
   end

   always @(posedge mclk) begin
      if (srst) begin
         sck_d_q <= 1'b0;
         cs_d_q <= 1'b1;
         state_q <= S_IDLE;
         cnt_q <= 5'h00;
         in_sr_q <= 32'h0;
         opc_q <= 8'h00;
         op_done_q <= 1'b0;
         dec_q <= 19'h00000;
         out_sr_q <= 8'h00;
         out_cnt_q <= 4'h0;
         rd_active_q <= 1'b0;
         rd_ptr_q <= {ADDR_BITS{1'b0}};
         credit_q <= {CW{1'b0}};
         rcv_cnt_q <= 32'h0;
         sio_out <= 4'h0;
         sio_oe_n <= `OE_N_ALL_OFF;
         erase_valid <= 1'b0;
         erase_block <= 1'b0;
         erase_addr <= {ADDR_BITS{1'b0}};
         write_abort <= 1'b0;
         status_q <= `STATUS_RST;
         io_configuration_bit <= `IO_CFG_RST;
         burst_len_q <= `BURST_RST;
         quad_mode_q <= 1'b0;
         reset_armed_q <= 1'b0;
         sw_reset_pulse <= 1'b0;
      end else begin
         sck_d_q <= sck_s;
         cs_d_q <= cs_s;
         erase_valid <= 1'b0;
         write_abort <= 1'b0;
         sw_reset_pulse <= 1'b0;
         if (rcv_cnt_q != 32'h0) begin
            rcv_cnt_q <= rcv_cnt_q - 32'h1;
         end
         if (status_wr) begin
            status_q <= status_wdata;
         end
         if (io_cfg_wr) begin
            io_configuration_bit <= io_cfg_wdata;
         end
         if (burst_wr) begin
            burst_len_q <= burst_wdata;
         end
         // credits cover requests in flight plus bytes queued
         if (!rd_active_q) begin
            credit_q <= {CW{1'b0}};
         end else if (req_take && !popped) begin
            credit_q <= credit_q + 1'b1;
         end else if (!req_take && popped) begin
            credit_q <= credit_q - 1'b1;
         end
         if (req_take) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end

         if (cs_rise) begin
            // frame ends; unfinished opcodes have no effect
            state_q <= S_IDLE;
            rd_active_q <= 1'b0;
            sio_oe_n <= `OE_N_ALL_OFF;
            op_done_q <= 1'b0;
            if (op_done_q) begin
               reset_armed_q <= (opc_q == `OP_RESET_ARM);
               if (opc_q == `OP_QUAD_ENTER) begin
                  quad_mode_q <= 1'b1;
               end
               if (opc_q == `OP_QUAD_EXIT) begin
                  quad_mode_q <= 1'b0;
               end
               if (dec_q[17] && state_q == S_SKIP) begin
                  erase_valid <= 1'b1;
               end
               if (opc_q == `OP_RESET_GO && reset_armed_q) begin
                  sw_reset_pulse <= 1'b1;
                  quad_mode_q <= 1'b0;
                  burst_len_q <= `BURST_RST;
                  status_q <= status_q & `STATUS_KEEP;
                  io_configuration_bit <= `IO_CFG_RST;
                  write_abort <= array_busy;
                  rcv_cnt_q <= array_busy ? RCV_WRITE_CYC :
                     RCV_OTHER_CYC;
               end
            end
         end else begin
            case (state_q)
               S_IDLE: begin
                  if (cs_fall) begin
                     // busy recovering: frame is swallowed
                     state_q <= dev_ready ? S_OPC : S_SKIP;
                     cnt_q <= quad_mode_q ? `OPC_CLK_QUAD
                        : `OPC_CLK_SER;
                  end
               end
               S_OPC: begin
                  if (sck_rise) begin
                     in_sr_q <= in_sr_d;
                     cnt_q <= cnt_q - 5'h01;
                     if (cnt_q == 5'h01) begin
                        opc_q <= in_sr_d[7:0];
                        op_done_q <= 1'b1;
                        dec_q <= dec_now;
                        cnt_q <= dec_now[12:8];
                        state_q <= (dec_now[18] | dec_now[17]) ? S_ADDR
                           : S_SKIP;
                     end
                  end
               end
               S_ADDR: begin
                  if (sck_rise) begin
                     in_sr_q <= in_sr_d;
                     cnt_q <= cnt_q - 5'h01;
                     if (cnt_q == 5'h01) begin
                        if (dec_q[17]) begin
                           erase_block <= dec_q[16];
                           erase_addr <= erase_base(addr_in, dec_q[16]);
                           state_q <= S_SKIP;
                        end else begin
                           rd_ptr_q <= addr_in;
                           rd_active_q <= 1'b1;
                           out_cnt_q <= 4'h0;
                           cnt_q <= dummy_clk;
                           state_q <= (dummy_clk == `DUMMY_CLK_NONE) ?
                              S_DATA : S_DUMMY;
                        end
                     end
                  end
               end
               S_DUMMY: begin
                  if (sck_rise) begin
                     cnt_q <= cnt_q - 5'h01;
                     if (cnt_q == 5'h01) begin
                        state_q <= S_DATA;
                     end
                  end
               end
               S_DATA: begin
                  if (sck_fall) begin
                     sio_oe_n <= lane_oe_n(d_lanes);
                     if (out_cnt_q == 4'h0) begin
                        // an empty queue sends zero rather than stalling
                        sio_out <= lane_bits(popped ? fifo_data : 8'h00,
                           d_lanes);
                        out_sr_q <= (popped ? fifo_data : 8'h00) << d_lanes;
                        out_cnt_q <= `BYTE_BITS - {1'b0, d_lanes};
                     end else begin
                        sio_out <= lane_bits(out_sr_q, d_lanes);
                        out_sr_q <= out_sr_q << d_lanes;
                        out_cnt_q <= out_cnt_q - {1'b0, d_lanes};
                     end
                  end
               end
               S_SKIP: begin
                  sio_oe_n <= `OE_N_ALL_OFF;
               end
               default: state_q <= S_IDLE;
            endcase
         end
      end
   end
endmodule // flash_front_end

// File: tb/flash_front_sva.sv
// Purpose: port-level checks on the flash command front end
// Assumes: bound to flash_front_end, one mclk domain
// Notes: recovery bounds follow the instance's cycle parameters
`timescale 1ns/1ns
module flash_front_sva #(
   parameter ADDR_BITS = 21,
   parameter RCV_WRITE_CYC = 20,
   parameter RCV_OTHER_CYC = 8
) (
   // clock and reset
   input wire mclk,
   input wire srst,
   // pins
   input wire cs_n,
   input wire [3:0] sio_oe_n,
   input wire arr_req_valid,
   // erase and abort
   input wire erase_valid,
   input wire erase_block,
   input wire [ADDR_BITS-1:0] erase_addr,
   input wire array_busy,
   input wire write_abort,
   // status and mode
   input wire [7:0] status_q,
   input wire io_configuration_bit,
   input wire [1:0] burst_len_q,
   input wire quad_mode_q,
   input wire reset_armed_q,
   input wire sw_reset_pulse,
   input wire dev_ready
);
   reg [15:0] low_cnt_q;
   reg aborted_q;
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   // low_cnt_q holds the length of the last recovery when ready rises
   always @(posedge mclk) begin
      if (srst || dev_ready)
         low_cnt_q <= 16'h0000;
      else
         low_cnt_q <= low_cnt_q + 16'h0001;
      if (srst || $rose(dev_ready))
         aborted_q <= 1'b0;
      else if (write_abort)
         aborted_q <= 1'b1;
   end
   a_oe_release: assert property (
      $rose(cs_n) |-> ##[1:8] sio_oe_n == 4'hF) else $error("pins held");
   a_reset_clears: assert property (
      sw_reset_pulse |-> ##[0:1] (!quad_mode_q && !io_configuration_bit
      && burst_len_q == 2'h0)) else $error("reset left mode");
   a_status_keep: assert property (
      sw_reset_pulse |-> ##[0:1] (status_q & 8'hCF) == 8'h00)
      else $error("status not cleared");
   a_reset_armed: assert property (
      sw_reset_pulse |-> $past(reset_armed_q)) else $error("reset unarmed");
   a_abort_busy: assert property (
      sw_reset_pulse && array_busy |-> ##[0:1] write_abort)
      else $error("no abort");
   a_recover_len: assert property (
      $rose(dev_ready) |-> low_cnt_q >= RCV_OTHER_CYC - 1
      && low_cnt_q <= RCV_WRITE_CYC + 1) else $error("recovery length");
   a_recover_write: assert property (
      $rose(dev_ready) && aborted_q |-> low_cnt_q >= RCV_WRITE_CYC - 1)
      else $error("write recovery short");
   a_quad_lanes: assert property (
      quad_mode_q |-> sio_oe_n == 4'hF || sio_oe_n == 4'h0)
      else $error("lanes in quad");
   a_no_quad_read: assert property (
      quad_mode_q && $past(quad_mode_q, 4) |-> !arr_req_valid)
      else $error("read in quad");
   a_sector_base: assert property (
      erase_valid && !erase_block |-> erase_addr[11:0] == 12'h000)
      else $error("sector base");
   a_block_base: assert property (
      erase_valid && erase_block |-> erase_addr[12:0] == 13'h0000)
      else $error("block base");
endmodule // flash_front_sva

// File: tb/flash_host_model.sv
// Purpose: host controller driving chip select, serial clock and data
// Assumes: mode 0, clock idles low, period 125 ns unrelated to mclk
// Notes: released lines show the inverse of the last driven value
`timescale 1ns/1ns
module flash_host_model (
   // clock
   input wire mclk,
   // flash pins
   output reg cs_n,
   output reg sck,
   output reg [3:0] sio_drv,
   input wire [3:0] sio_pin
);
   integer i;
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      sio_drv = 4'h0;
   end
   // tx goes out msb first, then nrd bytes are read on sio line 1
   task frame(input q, input [31:0] tx, input integer nbits,
      input integer nrd, output [15:0] rx);
      begin
         rx = 16'h0000;
         @(posedge mclk);
         cs_n <= 1'b0;
         #63;
         for (i = 0; i < (q ? nbits / 4 : nbits); i = i + 1) begin
            if (q)
               sio_drv <= tx[31:28];
            else
               sio_drv <= {sio_drv[3:1], tx[31]};
            tx = q ? tx << 4 : tx << 1;
            #62;
            sck <= 1'b1;
            #63;
            sck <= 1'b0;
         end
         sio_drv <= ~sio_drv;
         for (i = 0; i < nrd * 8; i = i + 1) begin
            #62;
            rx = {rx[14:0], sio_pin[1]};
            sck <= 1'b1;
            #63;
            sck <= 1'b0;
         end
         #63;
         cs_n <= 1'b1;
         sio_drv <= ~sio_drv;
         #400;
      end
   endtask
endmodule // flash_host_model

// File: tb/flash_front_end_tb_top.sv
// Purpose: self-checking bench for the flash command front end
// Assumes: short recovery counts, array answers in one or two cycles
// Notes: array byte is its address xor A5 so wrap shows in the data
`timescale 1ns/1ns
module flash_front_end_tb_top;
   localparam RW = 20;
   localparam RO = 8;
   localparam LIMIT = 60000;
   reg mclk = 1'b0, srst = 1'b1, pend_q = 1'b0, array_busy = 1'b0;
   reg [7:0] arr_rd_data = 8'h00, status_wdata = 8'h00;
   reg status_wr = 1'b0, io_cfg_wr = 1'b0, io_cfg_wdata = 1'b0;
   reg burst_wr = 1'b0;
   reg [1:0] burst_wdata = 2'h0;
   reg seen_rst = 1'b0, seen_abort = 1'b0, seen_req = 1'b0;
   reg [21:0] ea_q = 22'h0;
   reg [15:0] rx;
   integer failures = 0, check_count = 0, cyc = 0, lowc = 0;
   wire cs_n, sck, arr_req_valid, arr_rd_ready, erase_valid, erase_block;
   wire write_abort, io_configuration_bit, quad_mode_q, reset_armed_q;
   wire sw_reset_pulse, dev_ready;
   wire [3:0] sio_drv, sio_out, sio_oe_n;
   wire [3:0] sio_pin = (sio_oe_n & sio_drv) | (~sio_oe_n & sio_out);
   wire [20:0] arr_req_addr, erase_addr;
   wire [7:0] status_q;
   wire [1:0] burst_len_q;
   always #2 mclk = ~mclk;
   flash_front_end #(.RCV_WRITE_CYC(RW), .RCV_OTHER_CYC(RO))
   u_flash_front_end (.mclk(mclk), .srst(srst), .cs_n(cs_n), .sck(sck),
      .sio_in(sio_pin), .sio_out(sio_out), .sio_oe_n(sio_oe_n),
      .arr_req_valid(arr_req_valid), .arr_req_ready(!pend_q),
      .arr_req_addr(arr_req_addr), .arr_rd_valid(pend_q),
      .arr_rd_ready(arr_rd_ready), .arr_rd_data(arr_rd_data),
      .erase_valid(erase_valid), .erase_block(erase_block),
      .erase_addr(erase_addr), .array_busy(array_busy),
      .write_abort(write_abort), .status_wr(status_wr),
      .status_wdata(status_wdata), .status_q(status_q),
      .io_cfg_wr(io_cfg_wr), .io_cfg_wdata(io_cfg_wdata),
      .io_configuration_bit(io_configuration_bit), .burst_wr(burst_wr),
      .burst_wdata(burst_wdata), .burst_len_q(burst_len_q),
      .quad_mode_q(quad_mode_q), .reset_armed_q(reset_armed_q),
      .sw_reset_pulse(sw_reset_pulse), .dev_ready(dev_ready));
   flash_host_model u_flash_host_model (.mclk(mclk), .cs_n(cs_n),
      .sck(sck), .sio_drv(sio_drv), .sio_pin(sio_pin));
   always @(posedge mclk) begin
      if (arr_req_valid && !pend_q) begin
         pend_q <= 1'b1;
         arr_rd_data <= arr_req_addr[7:0] ^ 8'hA5;
      end else if (pend_q && arr_rd_ready) begin
         pend_q <= 1'b0;
      end
      if (sw_reset_pulse) seen_rst <= 1'b1;
      if (write_abort) seen_abort <= 1'b1;
      if (arr_req_valid) seen_req <= 1'b1;
      if (erase_valid) ea_q <= {erase_block, erase_addr};
      if (!dev_ready) lowc <= lowc + 1;
      cyc = cyc + 1;
      if (cyc == LIMIT) begin
         failures = failures + 1;
         report_and_stop;
      end
   end
   task chk(input [23:0] got, input [23:0] exp);
      begin
         check_count = check_count + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task fr(input q, input [31:0] tx, input integer n, input integer r);
      u_flash_host_model.frame(q, tx, n, r, rx);
   endtask
   task t_read_wrap;
      begin
         chk(quad_mode_q, 1'b0);
         fr(0, {8'h03, 24'hFFFFFF}, 32, 2);
         chk(rx, 16'h5AA5);
         fr(0, {8'h3B, 24'h000010}, 40, 2);
         chk(rx, 16'hCCDD);
         $display("test read_wrap done");
      end
   endtask
   task t_reset(input busy);
      begin
         @(posedge mclk);
         status_wr <= 1'b1;
         status_wdata <= 8'hFF;
         io_cfg_wr <= 1'b1;
         io_cfg_wdata <= 1'b1;
         burst_wr <= 1'b1;
         burst_wdata <= 2'h3;
         array_busy <= busy;
         @(posedge mclk);
         status_wr <= 1'b0;
         io_cfg_wr <= 1'b0;
         burst_wr <= 1'b0;
         {seen_rst, seen_abort} <= 2'b00;
         lowc <= 0;
         fr(0, {8'h66, 24'h0}, 8, 0);
         chk(reset_armed_q, 1'b1);
         fr(0, {8'h99, 24'h0}, 8, 0);
         chk(seen_rst, 1'b1);
         chk(status_q, 8'h30);
         chk({io_configuration_bit, burst_len_q}, 3'h0);
         chk(seen_abort, busy);
         chk(lowc > RO + 1, busy);
         @(posedge mclk);
         array_busy <= 1'b0;
         $display("test reset done");
      end
   endtask
   task t_cancel;
      begin
         @(posedge mclk);
         seen_rst <= 1'b0;
         fr(0, {8'h66, 24'h0}, 8, 0);
         fr(0, 32'h0, 4, 0);
         chk(reset_armed_q, 1'b1);
         fr(0, {8'h00, 24'h0}, 8, 0);
         chk(reset_armed_q, 1'b0);
         fr(0, {8'h99, 24'h0}, 8, 0);
         chk(seen_rst, 1'b0);
         $display("test cancel done");
      end
   endtask
   task t_quad;
      begin
         @(posedge mclk);
         seen_req <= 1'b0;
         fr(0, {8'h6B, 24'h0}, 32, 0);
         fr(0, {8'hEB, 24'h0}, 32, 0);
         fr(0, {8'h38, 24'h0}, 8, 0);
         chk(quad_mode_q, 1'b1);
         fr(1, {8'h03, 24'h000010}, 32, 0);
         chk({seen_req, quad_mode_q}, 2'h1);
         fr(1, {8'hFF, 24'h0}, 8, 0);
         chk(quad_mode_q, 1'b0);
         fr(0, {8'hFF, 24'h0}, 8, 0);
         chk(quad_mode_q, 1'b0);
         $display("test quad done");
      end
   endtask
   task t_erase;
      begin
         fr(0, {8'h20, 24'h123456}, 32, 0);
         chk(ea_q, 24'h123000);
         fr(0, {8'hD8, 24'h0A5678}, 32, 0);
         chk(ea_q, 24'h2A0000);
         fr(0, {8'hD8, 24'hE03456}, 32, 0);
         chk(ea_q, 24'h202000);
         $display("test erase done");
      end
   endtask
   task report_and_stop;
      begin
         $display("checks=%0d failures=%0d", check_count, failures);
         if (failures == 0 && check_count > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   initial begin
      repeat (10) @(posedge mclk);
      srst <= 1'b0;
      repeat (3) @(posedge mclk);
      t_read_wrap;
      t_reset(1'b0);
      t_reset(1'b1);
      t_cancel;
      t_quad;
      t_erase;
      report_and_stop;
   end
endmodule // flash_front_end_tb_top
bind flash_front_end flash_front_sva #(.ADDR_BITS(ADDR_BITS),
   .RCV_WRITE_CYC(RCV_WRITE_CYC), .RCV_OTHER_CYC(RCV_OTHER_CYC))
u_sva (.mclk(mclk), .srst(srst), .cs_n(cs_n), .sio_oe_n(sio_oe_n),
   .arr_req_valid(arr_req_valid), .erase_valid(erase_valid),
   .erase_block(erase_block), .erase_addr(erase_addr),
   .array_busy(array_busy), .write_abort(write_abort),
   .status_q(status_q), .io_configuration_bit(io_configuration_bit),
   .burst_len_q(burst_len_q), .quad_mode_q(quad_mode_q),
   .reset_armed_q(reset_armed_q), .sw_reset_pulse(sw_reset_pulse),
   .dev_ready(dev_ready));
